/* File: hdl/sevt_pkg.sv */
package sevt_pkg;
  // -----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL   = 16'hC000;
  localparam logic [15:0] IDX_START  = 16'hC002;
  localparam logic [15:0] IDX_END    = 16'hC004;
  localparam logic [15:0] IDX_CUR    = 16'hC006;
  localparam logic [15:0] IDX_STATUS = 16'hC008;
  localparam logic [15:0] IDX_MASK   = 16'hC00A;
  // -----------------------------------------------------------------
  // reset values and field layout
  // -----------------------------------------------------------------
  localparam logic [15:0] RST_REG    = 16'h0000;
  localparam int          CTRL_W     = 10;
  localparam int          PRE_W      = 18;
  localparam logic [4:0]  PRE_BASE   = 5'h02;
  localparam int          TRIG_NS    = 50;
  localparam int          CLK_NS     = 25;
  localparam int          TRIG_CYC   = TRIG_NS / CLK_NS;
  localparam int          EVT_BIT    = 0;

  // control register fields, bit 9 downward
  typedef struct packed {
    logic [3:0] frequency_select;
    logic       clock_mode_select;
    logic       trigger_output_enable;
    logic       continue_on_match;
    logic       reload_enable;
    logic       count_direction;
    logic       timer_enable_bit;
  } sevt_ctrl_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } sevt_state_t;
endpackage : sevt_pkg

/* File: hdl/sevt_timer.sv */
// How it works
// [R1] reload start value on match with reload, continue
// [R2] first counting edge after enable loads start
// [R3] count compared with end value always
// [R4] current count readable, never writable
// [R5] six registers, at every second index, reset to zero
// [R6] counting clock comes from the prescaler
// [R7] counter source: start, incrementer or decrementer
// [R8] match triggers output, then reload/stop/continue
// [R9] software leaves settings alone while enabled
// [R10] software configures only while timer disabled
// [R11] trigger is match edge, two cycles long
// [R12] clock mode zero uses internal prescaled clock
// [R13] prescaler divides by two to (2+select)
// [R14] direction zero counts down, one up
// [R15] no reload: continue counts on, else freezes
// [R16] trigger pulses only with output enable set
// [R17] disabled timer holds count, no triggers
`timescale 1ns/1ps
`default_nettype none
module sevt_timer (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [17:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             injection_trigger_out_o,
  output logic             irq_o
);
  // -----------------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------------
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] idx;
  logic        req;
  logic        wr_go;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] wctl;

  sevt_pkg::sevt_ctrl_t  ctrl_q, ctrl_d;
  logic [15:0]           start_q, start_d;
  logic [15:0]           end_q, end_d;
  logic [15:0]           cur_q, cur_d;
  logic                  stat_q, stat_d;
  logic                  mask_q, mask_d;
  sevt_pkg::sevt_state_t st_q, st_d;
  logic [sevt_pkg::PRE_W-1:0] pre_q, pre_d;
  logic [sevt_pkg::PRE_W-1:0] pre_mask;
  logic                  tick;
  logic                  match;
  logic                  mflag_q, mflag_d;
  logic                  rise;
  logic                  p1_q, p1_d;
  logic                  trig_q, trig_d;

  // one wait cycle per request, answer on the second edge
  always_comb begin
    idx   = avs_address_i[17:2];
    req   = avs_read_i | avs_write_i;
    ack_d = req & ~ack_q;
    wr_go = avs_write_i & ack_q;
    wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    avs_waitrequest_o = req & ~ack_q;
  end

  // read mux, unmapped indices read zero
  always_comb begin
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q) begin
      rdata_d = 32'h0000_0000;
      unique case (idx)
        sevt_pkg::IDX_CTRL:   rdata_d[sevt_pkg::CTRL_W-1:0] = ctrl_q;
        sevt_pkg::IDX_START:  rdata_d[15:0] = start_q;
        sevt_pkg::IDX_END:    rdata_d[15:0] = end_q;
        sevt_pkg::IDX_CUR:    rdata_d[15:0] = cur_q;  // R4
        sevt_pkg::IDX_STATUS: rdata_d[0] = stat_q;
        sevt_pkg::IDX_MASK:   rdata_d[0] = mask_q;
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // register writes; current count has no write path
  always_comb begin
    wval   = avs_writedata_i[15:0];
    wctl   = 16'h0000;
    ctrl_d = ctrl_q;
    start_d = start_q;
    end_d  = end_q;
    mask_d = mask_q;
    if (wr_go && idx == sevt_pkg::IDX_CTRL) begin  // R5
      // merge lanes, then keep only the implemented control bits
      wctl   = (16'(ctrl_q) & ~wmask | wval & wmask) & 16'h03FF;
      ctrl_d = sevt_pkg::sevt_ctrl_t'(wctl[sevt_pkg::CTRL_W-1:0]);
    end
    if (wr_go && idx == sevt_pkg::IDX_START) begin
      start_d = start_q & ~wmask | wval & wmask;  // R1
    end
    if (wr_go && idx == sevt_pkg::IDX_END) begin
      end_d = end_q & ~wmask | wval & wmask;  // R3
    end
    if (wr_go && idx == sevt_pkg::IDX_MASK && avs_byteenable_i[0]) begin
      mask_d = wval[0];
    end
  end

  // sticky match status, a new event wins over the clear
  always_comb begin
    stat_d = stat_q;
    if (wr_go && idx == sevt_pkg::IDX_STATUS && avs_byteenable_i[0]
        && wval[sevt_pkg::EVT_BIT]) begin
      stat_d = 1'b0;
    end
    if (rise) begin
      stat_d = 1'b1;
    end
  end

  assign irq_o          = stat_q & mask_q;
  assign avs_readdata_o = rdata_q;

  // bus and register flops, all zero after reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q  <= sevt_pkg::sevt_ctrl_t'(sevt_pkg::RST_REG[9:0]);  // R5
      start_q <= sevt_pkg::RST_REG;
      end_q   <= sevt_pkg::RST_REG;
      stat_q  <= 1'b0;
      mask_q  <= 1'b0;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q  <= ctrl_d;
      start_q <= start_d;
      end_q   <= end_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
    end
  end

  // -----------------------------------------------------------------
  // prescaler and counter
  // -----------------------------------------------------------------
  // tick once every 2**(2+select) cycles while enabled in clock mode zero
  always_comb begin
    pre_mask = ~({sevt_pkg::PRE_W{1'b1}}
                 << (sevt_pkg::PRE_BASE + {1'b0, ctrl_q.frequency_select}));  // R13
    pre_d = (st_q == sevt_pkg::ST_OFF) ? '0 : pre_q + 18'h00001;
    tick  = (st_q != sevt_pkg::ST_OFF) && ctrl_q.timer_enable_bit
            && !ctrl_q.clock_mode_select                          // R12
            && ((pre_q & pre_mask) == pre_mask);                  // R6
    match = (cur_q == end_q);                                     // R3
  end

  // timer state and next count
  always_comb begin
    st_d  = st_q;
    cur_d = cur_q;
    unique case (st_q)
      sevt_pkg::ST_OFF: begin
        if (ctrl_q.timer_enable_bit) begin
          st_d = sevt_pkg::ST_ARM;
        end
      end
      sevt_pkg::ST_ARM: begin
        if (tick) begin
          cur_d = start_q;  // R2
          st_d  = sevt_pkg::ST_RUN;
        end
      end
      sevt_pkg::ST_RUN: begin
        if (tick) begin
          if (match && ctrl_q.reload_enable && ctrl_q.continue_on_match) begin
            cur_d = start_q;  // R1 R7 R8
          end else if (match && !ctrl_q.continue_on_match) begin
            cur_d = cur_q;  // R15
          end else if (ctrl_q.count_direction) begin
            cur_d = cur_q + 16'h0001;  // R14 R7
          end else begin
            cur_d = cur_q - 16'h0001;  // R14 R7
          end
        end
      end
    endcase
    if (!ctrl_q.timer_enable_bit) begin
      st_d  = sevt_pkg::ST_OFF;  // R17
      cur_d = cur_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_q  <= sevt_pkg::ST_OFF;
      pre_q <= '0;
      cur_q <= sevt_pkg::RST_REG;  // R5
    end else begin
      st_q  <= st_d;
      pre_q <= pre_d;
      cur_q <= cur_d;
    end
  end

  // -----------------------------------------------------------------
  // trigger output
  // -----------------------------------------------------------------
  // edge of the running match flag, stretched to two cycles
  always_comb begin
    mflag_d = (st_q == sevt_pkg::ST_RUN) && ctrl_q.timer_enable_bit && match;  // R17
    rise    = mflag_d && !mflag_q;  // R11
    p1_d    = rise && ctrl_q.trigger_output_enable;  // R16 R8
    trig_d  = p1_d || p1_q;  // R11
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mflag_q <= 1'b0;
      p1_q    <= 1'b0;
      trig_q  <= 1'b0;
    end else begin
      mflag_q <= mflag_d;
      p1_q    <= p1_d;
      trig_q  <= trig_d;
    end
  end

  assign injection_trigger_out_o = trig_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_pulse;
    injection_trigger_out_o ##1 injection_trigger_out_o ##1 !injection_trigger_out_o;
  endsequence

  chk_trig_two_cycles: assert property ($rose(injection_trigger_out_o) |-> s_pulse) // R11
    else $error("trigger pulse not two cycles");
  chk_trig_gated_off: assert property (
    !ctrl_q.trigger_output_enable && !$past(ctrl_q.trigger_output_enable, 2)
    && !$past(ctrl_q.trigger_output_enable) |-> !injection_trigger_out_o) // R16
    else $error("trigger with output disabled");
  chk_hold_disabled: assert property (!ctrl_q.timer_enable_bit |=> $stable(cur_q)) // R17
    else $error("count moved while disabled");
  chk_first_load: assert property (
    st_q == sevt_pkg::ST_ARM && tick |=> cur_q == $past(start_q)) // R2
    else $error("start value not loaded");
  chk_reload_match: assert property (
    st_q == sevt_pkg::ST_RUN && tick && match && ctrl_q.reload_enable
    && ctrl_q.continue_on_match |=> cur_q == $past(start_q)) // R1
    else $error("reload on match missing");
  chk_stop_freeze: assert property (
    st_q == sevt_pkg::ST_RUN && tick && match && !ctrl_q.continue_on_match
    |=> $stable(cur_q)) // R15
    else $error("stop mode did not freeze");
  chk_count_up: assert property (
    st_q == sevt_pkg::ST_RUN && tick && !match && ctrl_q.count_direction
    |=> cur_q == $past(cur_q) + 16'h0001) // R14
    else $error("up count wrong");
  chk_count_down: assert property (
    st_q == sevt_pkg::ST_RUN && tick && !match && !ctrl_q.count_direction
    |=> cur_q == $past(cur_q) - 16'h0001) // R14
    else $error("down count wrong");
  chk_tick_spacing: assert property (
    tick && ctrl_q.frequency_select == 4'h0 |=> !tick [*3]) // R13
    else $error("prescaler faster than four");
  chk_bus_answer: assert property (
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");

  // -----------------------------------------------------------------
  // checks: events and idle state
  // -----------------------------------------------------------------
  // a match edge always lands in the sticky status
  chk_status_set: assert property ( // R8
    rise |=> stat_q)
    else $error("match event not recorded");
  chk_trig_needs_enable: assert property ( // R16
    $rose(injection_trigger_out_o) |-> $past(ctrl_q.trigger_output_enable))
    else $error("trigger rose without output enable");
  // a timer that is off neither ticks nor flags a match
  chk_off_no_tick: assert property ( // R17
    st_q == sevt_pkg::ST_OFF |-> !tick)
    else $error("tick while timer off");
  chk_off_no_match: assert property ( // R17
    !ctrl_q.timer_enable_bit |=> !mflag_q)
    else $error("match flag while disabled");
  chk_arm_from_off: assert property ( // R2
    st_q == sevt_pkg::ST_OFF && ctrl_q.timer_enable_bit
    |=> st_q == sevt_pkg::ST_ARM)
    else $error("enable did not arm timer");
  chk_pre_restart: assert property ( // R6
    st_q == sevt_pkg::ST_OFF |=> pre_q == '0)
    else $error("prescaler not restarted");
endmodule : sevt_timer
`default_nettype wire

/* File: testbench/sevt_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// converter injection input: counts pulses, width and spacing
// -----------------------------------------------------------------
module sevt_adc_model (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic trig_i,
  output var  int   pulses_o,
  output var  int   width_o,
  output var  int   gap_o
);
  int   run_q;
  int   since_q;
  logic prev_q;
  // high runs give the width, rise to rise gives the spacing
  always @(posedge mclk_i) begin
    if (srst_i) begin
      pulses_o <= 0;
      width_o  <= 0;
      gap_o    <= 0;
      run_q    <= 0;
      since_q  <= 0;
      prev_q   <= 1'b0;
    end else begin
      since_q <= since_q + 1;
      prev_q  <= trig_i;
      if (trig_i) begin
        run_q <= run_q + 1;
      end else if (run_q != 0) begin
        width_o <= run_q;
        run_q   <= 0;
      end
      if (trig_i && !prev_q) begin
        pulses_o <= pulses_o + 1;
        gap_o    <= since_q;
        since_q  <= 1;
      end
    end
  end
endmodule : sevt_adc_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [17:0] avs_address_i = 18'h00000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        injection_trigger_out_o;
  logic        irq_o;
  logic [15:0] rv;
  logic [15:0] held;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          pulses;
  int          width;
  int          gap;
  int          p0;
  int          i;

  always #12.5 mclk_i = ~mclk_i;

  sevt_timer sevt_timer_inst (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .injection_trigger_out_o(injection_trigger_out_o), .irq_o(irq_o));
  sevt_adc_model sevt_adc_model_inst (.mclk_i(mclk_i), .srst_i(srst_i),
    .trig_i(injection_trigger_out_o), .pulses_o(pulses), .width_o(width), .gap_o(gap));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one bus cycle, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [15:0] idx, input logic [15:0] d);
    @(posedge mclk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {16'h0000, d};
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge mclk_i iff avs_waitrequest_o === 1'b0);
    rv = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : acc

  task automatic rdc(input string n, input logic [15:0] idx, input logic [15:0] e);
    acc(1'b0, idx, 16'h0000);
    chk(n, {16'h0000, e}, {16'h0000, rv});
  endtask : rdc

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rdc("reset value", 16'hC000 + 16'(2 * i), 16'h0000);
    end
    rdc("unmapped", 16'hC00C, 16'h0000);
    acc(1'b1, sevt_pkg::IDX_CUR, 16'h1234);
    rdc("current write", sevt_pkg::IDX_CUR, 16'h0000);
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'hFFFE);
    rdc("control bits", sevt_pkg::IDX_CTRL, 16'h03FE);
    $display("test registers done");
    // up count with reload, spacing set by the prescaler
    acc(1'b1, sevt_pkg::IDX_START, 16'h0005);
    acc(1'b1, sevt_pkg::IDX_END, 16'h0007);
    for (i = 0; i < 3; i++) begin
      acc(1'b1, sevt_pkg::IDX_CTRL, 16'(i << 6) | 16'h001E);
      p0 = pulses;
      acc(1'b1, sevt_pkg::IDX_CTRL, 16'(i << 6) | 16'h001F);
      // eight periods hold seven whole matches after the first load
      repeat (8 * (12 << i)) @(posedge mclk_i);
      chk("pulse count", 32'(p0 + 7), pulses);
      chk("pulse spacing", 32'(3 * (4 << i)), gap);
      chk("pulse width", 32'(2), width);
      acc(1'b1, sevt_pkg::IDX_CTRL, 16'(i << 6) | 16'h001E);
    end
    acc(1'b1, sevt_pkg::IDX_STATUS, 16'h0001);
    rdc("status cleared", sevt_pkg::IDX_STATUS, 16'h0000);
    $display("test reload done");
    // down count in stop mode, then event, mask and clear
    acc(1'b1, sevt_pkg::IDX_START, 16'h0003);
    acc(1'b1, sevt_pkg::IDX_END, 16'h0001);
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h0010);
    p0 = pulses;
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h0011);
    repeat (100) @(posedge mclk_i);
    chk("single pulse", 32'(p0 + 1), pulses);
    rdc("frozen count", sevt_pkg::IDX_CUR, 16'h0001);
    rdc("event status", sevt_pkg::IDX_STATUS, 16'h0001);
    chk("irq masked", 32'(0), 32'(irq_o));
    acc(1'b1, sevt_pkg::IDX_MASK, 16'h0001);
    repeat (2) @(posedge mclk_i);
    chk("irq raised", 32'(1), 32'(irq_o));
    acc(1'b1, sevt_pkg::IDX_STATUS, 16'h0001);
    repeat (2) @(posedge mclk_i);
    chk("irq cleared", 32'(0), 32'(irq_o));
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h0010);
    $display("test stop done");
    // output disabled, then hold while disabled
    acc(1'b1, sevt_pkg::IDX_START, 16'h0000);
    acc(1'b1, sevt_pkg::IDX_END, 16'h0002);
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h000E);
    p0 = pulses;
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h000F);
    repeat (60) @(posedge mclk_i);
    acc(1'b1, sevt_pkg::IDX_CTRL, 16'h000E);
    acc(1'b0, sevt_pkg::IDX_CUR, 16'h0000);
    held = rv;
    // fifteen ticks of 0,1,2 leave the count on two
    chk("count ran", 32'(2), {16'h0000, held});
    repeat (40) @(posedge mclk_i);
    rdc("held count", sevt_pkg::IDX_CUR, held);
    chk("no pulses", 32'(p0), pulses);
    $display("test hold done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
